// ---- ddrrd_defines.vh ----
// ddrrd_defines.vh: constants for the read burst path of a double-data-rate dram.
// assumes it is included by bare name from ddrrd_read_path.v and ddrrd_delay_line.v.
`ifndef DDRRD_DEFINES_VH
`define DDRRD_DEFINES_VH

// command pin pattern {cs_n, ras_n, cas_n, we_n} for a read
`define DDRRD_CMD_READ 4'h5

// burst length field of mode_register_zero
`define DDRRD_BL_FIXED8 2'h0
`define DDRRD_BL_OTF 2'h1
`define DDRRD_BL_FIXED4 2'h2

// additive_delay select of mode_register_one
`define DDRRD_AL_ZERO 2'h0
`define DDRRD_AL_CL_MINUS1 2'h1
`define DDRRD_AL_CL_MINUS2 2'h2

// address pin positions
`define DDRRD_COL_MSB 9
`define DDRRD_BLSEL_BIT 12

// beats per full burst and per chopped burst
`define DDRRD_BEATS_FULL 4'h8
`define DDRRD_BEATS_CHOP 4'h4

// preamble length in link clock cycles
`define DDRRD_PREAMBLE_NCK 1

// column latency limits accepted by the block
`define DDRRD_CL_MIN 4'h5
`define DDRRD_CL_MAX 4'hd

`endif

// ---- ddrrd_delay_line.v ----
// ddrrd_delay_line.v: shift line that holds pending read commands for a number of link clock cycles.
// assumes shift_i is a one-cycle pulse on each link clock rising edge, from the same system clock.
`timescale 1ns/10ps
`include "ddrrd_defines.vh"

module ddrrd_delay_line #(
    parameter W = 14,
    parameter D = 32,
    parameter AW = 5
) (
    input wire clk_i,
    input wire rst_i,
    input wire shift_i,
    input wire [W-1:0] din_i,
    input wire [AW-1:0] tap_i,
    output wire [W-1:0] tap_o
);

    reg [W-1:0] stage_reg [0:D-1];
    integer i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            for (i = 0; i < D; i = i + 1) begin
                stage_reg[i] <= {W{1'b0}};
            end
        end else if (shift_i) begin
            stage_reg[0] <= din_i;
            for (i = 1; i < D; i = i + 1) begin
                stage_reg[i] <= stage_reg[i-1];
            end
        end
    end

    // stage k holds the command that entered k+1 link edges ago
    assign tap_o = stage_reg[tap_i];

endmodule // ddrrd_delay_line

// ---- ddrrd_read_path.v ----
// ddrrd_read_path.v: read command decode, latency pipeline and strobe/data output drive of the dram.
// assumes the link clock and command pins come from the controller asynchronously, and that the
// array answers a fetch request with burst data one system clock later.
//
// How it works
// - a12 low requests a chopped four-beat burst, high a full one; chop gap is 4
// - a12 only picks burst length, never forms part of the column address
// - a read is cs_n and cas_n low, ras_n and we_n high at a rising edge
// - a full burst starts at the column sampled with the read command; a chopped one at the sampled a2 with a1 and a0 as 0
// - first read data appears total_read_delay cycles after the read command
// - strobe is driven low as a preamble one cycle before valid data
// - first beat aligns with first rising strobe edge; later beats follow the strobe
// - total_read_delay is additive_delay plus column_strobe_latency from the mode registers
// - strobe drive starts one cycle before read delay expires, data drive at expiry
// - drive stops four cycles after read delay for full bursts, two for chopped
// - burst length field: 00 fixed full, 01 per command choice, 10 fixed chopped
// - with a gap of 5 between full reads the strobe idles low between bursts
// - read timing is kept only while the delay-locked loop is enabled and locked
`timescale 1ns/10ps
`include "ddrrd_defines.vh"

module ddrrd_read_path #(
    parameter DW = 8,
    parameter AW = 14,
    parameter BAW = 3,
    parameter PIPE_D = 32,
    parameter PIPE_AW = 5
) (
    input wire SYS_CLK_I,
    input wire RST_I,
    input wire CK_I,
    input wire CS_N_I,
    input wire RAS_N_I,
    input wire CAS_N_I,
    input wire WE_N_I,
    input wire [AW-1:0] ADDR_I,
    input wire [BAW-1:0] BANK_I,
    input wire [1:0] BURST_MODE_I,
    input wire [3:0] COL_LATENCY_I,
    input wire [1:0] ADDITIVE_SEL_I,
    input wire DLL_ENABLE_I,
    input wire DLL_LOCKED_I,
    output wire RD_REQ_O,
    output wire [`DDRRD_COL_MSB:0] RD_COL_O,
    output wire [BAW-1:0] RD_BANK_O,
    input wire [8*DW-1:0] RD_DATA_I,
    output wire [DW-1:0] DQ_O,
    output wire DQ_OE_O,
    output wire DQS_O,
    output wire DQS_N_O,
    output wire DQS_OE_O,
    output wire [4:0] READ_DELAY_O
);

    localparam CW = `DDRRD_COL_MSB + 1;
    localparam PW = 1 + CW + BAW;

    // two-flop synchronisers for every pin from the controller's domain
    reg [5:0] pin_meta_reg;
    reg [5:0] pin_sync_reg;
    reg [AW+BAW-1:0] addr_meta_reg;
    reg [AW+BAW-1:0] addr_sync_reg;
    reg ck_last_reg;

    wire ck_s = pin_sync_reg[0];
    wire dll_ok = pin_sync_reg[5];
    wire ck_rise = ck_s & ~ck_last_reg;
    wire ck_fall = ~ck_s & ck_last_reg;
    wire [3:0] cmd_pins = pin_sync_reg[4:1];

    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            pin_meta_reg <= 6'h1e;
            pin_sync_reg <= 6'h1e;
            addr_meta_reg <= {(AW+BAW){1'b0}};
            addr_sync_reg <= {(AW+BAW){1'b0}};
            ck_last_reg <= 1'b0;
        end else begin
            pin_meta_reg <= {DLL_ENABLE_I & DLL_LOCKED_I, CS_N_I, RAS_N_I, CAS_N_I, WE_N_I, CK_I};
            pin_sync_reg <= pin_meta_reg;
            addr_meta_reg <= {BANK_I, ADDR_I};
            addr_sync_reg <= addr_meta_reg;
            ck_last_reg <= ck_s;
        end
    end

    // total_read_delay = additive_delay + column_strobe_latency
    function [4:0] read_delay;
        input [3:0] cl;
        input [1:0] al_sel;
        begin
            case (al_sel)
                `DDRRD_AL_CL_MINUS1: read_delay = {1'b0, cl} + {1'b0, cl} - 5'h01;
                `DDRRD_AL_CL_MINUS2: read_delay = {1'b0, cl} + {1'b0, cl} - 5'h02;
                default: read_delay = {1'b0, cl};
            endcase
        end
    endfunction

    // column latency outside the supported range is pulled to the nearest legal value
    function [3:0] clamp_cl;
        input [3:0] cl;
        begin
            if (cl < `DDRRD_CL_MIN) begin
                clamp_cl = `DDRRD_CL_MIN;
            end else if (cl > `DDRRD_CL_MAX) begin
                clamp_cl = `DDRRD_CL_MAX;
            end else begin
                clamp_cl = cl;
            end
        end
    endfunction

    // beats still to send after the first one, by burst length
    function [3:0] beats_after_first;
        input chop;
        begin
            beats_after_first = (chop ? `DDRRD_BEATS_CHOP : `DDRRD_BEATS_FULL) - 4'h1;
        end
    endfunction

    // sequential burst order inside the selected half, starting at the sampled low column bits
    function [2:0] beat_slot;
        input [2:0] start;
        input [2:0] idx;
        begin
            beat_slot = {start[2] ^ idx[2], start[1:0] + idx[1:0]};
        end
    endfunction

    wire [3:0] cl_clamped = clamp_cl(COL_LATENCY_I);
    wire [4:0] rl = read_delay(cl_clamped, ADDITIVE_SEL_I);
    // the line is read before its shift, so stage rl-2 holds a command issued rl-1 edges ago
    wire [31:0] tap_full = rl - 2 - `DDRRD_PREAMBLE_NCK + 1;
    wire [PIPE_AW-1:0] tap_idx = tap_full[PIPE_AW-1:0];

    // mode inputs are levels, so the reported delay needs no reset value of its own
    reg [4:0] read_delay_reg;

    always @(posedge SYS_CLK_I) begin
        read_delay_reg <= rl;
    end

    // decode; every other command pattern is ignored by this path
    wire is_read = ck_rise & dll_ok & (cmd_pins == `DDRRD_CMD_READ);
    wire a12 = addr_sync_reg[`DDRRD_BLSEL_BIT];
    reg chop_sel;

    always @* begin
        case (BURST_MODE_I)
            `DDRRD_BL_OTF: chop_sel = ~a12;
            `DDRRD_BL_FIXED4: chop_sel = 1'b1;
            default: chop_sel = 1'b0;
        endcase
    end

    // column excludes a10, a11 and a12; a12 steers burst length alone
    wire [CW-1:0] cmd_col = addr_sync_reg[`DDRRD_COL_MSB:0];
    wire [BAW-1:0] cmd_bank = addr_sync_reg[AW+BAW-1:AW];
    wire [PW-1:0] pipe_in = is_read ? {1'b1, cmd_col, cmd_bank} : {PW{1'b0}};
    wire [PW-1:0] pipe_tap;
    reg [PIPE_D-1:0] chop_line_reg;

    ddrrd_delay_line #(
        .W(PW),
        .D(PIPE_D),
        .AW(PIPE_AW)
    ) u_line (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .shift_i(ck_rise),
        .din_i(pipe_in),
        .tap_i(tap_idx),
        .tap_o(pipe_tap)
    );

    // burst length rides beside the command line so a later mode change cannot alter it
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            chop_line_reg <= {PIPE_D{1'b0}};
        end else if (ck_rise) begin
            chop_line_reg <= {chop_line_reg[PIPE_D-2:0], is_read & chop_sel};
        end
    end

    wire due_valid = ck_rise & pipe_tap[PW-1] & dll_ok;
    wire due_chop = chop_line_reg[tap_idx];

    // burst engine state
    reg req_reg;
    reg [CW-1:0] req_col_reg;
    reg [BAW-1:0] req_bank_reg;
    reg fetch_wait_reg;
    reg pend_valid_reg;
    reg pend_chop_reg;
    reg [2:0] pend_start_reg;
    reg [8*DW-1:0] pend_data_reg;
    reg [8*DW-1:0] burst_data_reg;
    reg [2:0] burst_start_reg;
    reg [3:0] beats_left_reg;
    reg [2:0] beat_idx_reg;
    reg [DW-1:0] dq_reg;
    reg dq_oe_reg;
    reg dqs_reg;
    reg dqs_oe_reg;

    wire [2:0] slot_now = beat_slot(burst_start_reg, beat_idx_reg);
    wire [2:0] slot_first = beat_slot(pend_start_reg, 3'h0);

    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            req_reg <= 1'b0;
            req_col_reg <= {CW{1'b0}};
            req_bank_reg <= {BAW{1'b0}};
            fetch_wait_reg <= 1'b0;
            pend_valid_reg <= 1'b0;
            pend_chop_reg <= 1'b0;
            pend_start_reg <= 3'h0;
            pend_data_reg <= {(8*DW){1'b0}};
            burst_data_reg <= {(8*DW){1'b0}};
            burst_start_reg <= 3'h0;
            beats_left_reg <= 4'h0;
            beat_idx_reg <= 3'h0;
            dq_reg <= {DW{1'b0}};
            dq_oe_reg <= 1'b0;
            dqs_reg <= 1'b0;
            dqs_oe_reg <= 1'b0;
        end else begin
            req_reg <= 1'b0;
            fetch_wait_reg <= req_reg;
            if (fetch_wait_reg) begin
                pend_data_reg <= RD_DATA_I;
            end
            if (!dll_ok) begin
                // without lock no timing can be promised, so the pins are released at once
                pend_valid_reg <= 1'b0;
                beats_left_reg <= 4'h0;
                dq_oe_reg <= 1'b0;
                dqs_oe_reg <= 1'b0;
                dqs_reg <= 1'b0;
            end else if (ck_rise) begin
                if (beats_left_reg != 4'h0) begin
                    // burst in flight continues; a seamless follower needs no preamble
                    dq_reg <= burst_data_reg[slot_now*DW +: DW];
                    dqs_reg <= 1'b1;
                    beats_left_reg <= beats_left_reg - 4'h1;
                    beat_idx_reg <= beat_idx_reg + 3'h1;
                end else if (pend_valid_reg) begin
                    // read delay expires here: first beat on the first rising strobe edge
                    burst_data_reg <= pend_data_reg;
                    burst_start_reg <= pend_start_reg;
                    dq_reg <= pend_data_reg[slot_first*DW +: DW];
                    dq_oe_reg <= 1'b1;
                    dqs_reg <= 1'b1;
                    dqs_oe_reg <= 1'b1;
                    beats_left_reg <= beats_after_first(pend_chop_reg);
                    beat_idx_reg <= 3'h1;
                    pend_valid_reg <= 1'b0;
                end else if (due_valid) begin
                    // preamble: strobe driven low, data still released; also the idle gap
                    dqs_oe_reg <= 1'b1;
                    dqs_reg <= 1'b0;
                    dq_oe_reg <= 1'b0;
                end else begin
                    // last beat has had its full cycle, release both groups
                    dq_oe_reg <= 1'b0;
                    dqs_oe_reg <= 1'b0;
                    dqs_reg <= 1'b0;
                end
                if (due_valid) begin
                    // fetch now so the burst data is ready well before the next rising edge
                    pend_valid_reg <= 1'b1;
                    pend_chop_reg <= due_chop;
                    pend_start_reg <= due_chop ? {pipe_tap[BAW+2], 2'h0} : pipe_tap[BAW+2:BAW];
                    req_reg <= 1'b1;
                    req_col_reg <= pipe_tap[BAW+CW-1:BAW];
                    req_bank_reg <= pipe_tap[BAW-1:0];
                end
            end else if (ck_fall && beats_left_reg != 4'h0) begin
                dq_reg <= burst_data_reg[slot_now*DW +: DW];
                dqs_reg <= 1'b0;
                beats_left_reg <= beats_left_reg - 4'h1;
                beat_idx_reg <= beat_idx_reg + 3'h1;
            end
        end
    end

    assign RD_REQ_O = req_reg;
    assign RD_COL_O = req_col_reg;
    assign RD_BANK_O = req_bank_reg;
    assign DQ_O = dq_reg;
    assign DQ_OE_O = dq_oe_reg;
    assign DQS_O = dqs_reg;
    assign DQS_N_O = ~dqs_reg;
    assign DQS_OE_O = dqs_oe_reg;
    assign READ_DELAY_O = read_delay_reg;

endmodule // ddrrd_read_path

// ---- ddrrd_read_path_properties.sv ----
// ddrrd_read_path_properties.sv: timing checks on the strobe, data and fetch outputs of the read path.
// assumes the link clock runs at one eighth of SYS_CLK_I, so one link half cycle is 4 system cycles.
`timescale 1ns/10ps
module ddrrd_chk (
    input wire SYS_CLK_I,
    input wire RST_I,
    input wire [3:0] COL_LATENCY_I,
    input wire [1:0] ADDITIVE_SEL_I,
    input wire DLL_ENABLE_I,
    input wire DLL_LOCKED_I,
    input wire RD_REQ_O,
    input wire DQ_OE_O,
    input wire DQS_O,
    input wire DQS_N_O,
    input wire DQS_OE_O,
    input wire [4:0] READ_DELAY_O
);
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RST_I);
    reg [6:0] oe_len_reg;
    reg [3:0] cl;
    reg [4:0] rl_exp;
    always @(posedge SYS_CLK_I) begin
        if (RST_I || !DQ_OE_O) oe_len_reg <= 7'h0;
        else oe_len_reg <= oe_len_reg + 7'h1;
    end
    always @* begin
        cl = (COL_LATENCY_I < 4'h5) ? 4'h5 : ((COL_LATENCY_I > 4'hd) ? 4'hd : COL_LATENCY_I);
        case (ADDITIVE_SEL_I)
            2'h1: rl_exp = {cl, 1'b0} - 5'h1;
            2'h2: rl_exp = {cl, 1'b0} - 5'h2;
            default: rl_exp = {1'b0, cl};
        endcase
    end
    sequence s_preamble;
        (!DQS_O && !DQ_OE_O)[*6];
    endsequence
    sequence s_first_beat;
        $rose(DQ_OE_O) && DQS_O;
    endsequence
    chk_preamble_low: assert property ($rose(DQS_OE_O) |-> s_preamble ##[1:4] s_first_beat)
        else $error("strobe preamble not one link cycle low before data");
    chk_strobe_pair: assert property (DQS_OE_O |-> DQS_N_O == !DQS_O)
        else $error("strobe pair not complementary");
    chk_dq_under_dqs: assert property (DQ_OE_O |-> DQS_OE_O)
        else $error("data driven without strobe");
    chk_beat_spacing: assert property (DQ_OE_O && $changed(DQS_O) |=> $stable(DQS_O)[*3])
        else $error("strobe edge spacing wrong");
    // seamless bursts merge, so one or two full bursts or one chopped burst are legal lengths
    chk_burst_length: assert property ($fell(DQ_OE_O) |-> (oe_len_reg >= 7'hf && oe_len_reg <= 7'h11)
        || (oe_len_reg >= 7'h1f && oe_len_reg <= 7'h21) || (oe_len_reg >= 7'h3f && oe_len_reg <= 7'h41))
        else $error("data drive window length wrong");
    chk_idle_low: assert property ($fell(DQ_OE_O) && DQS_OE_O |-> (DQS_OE_O && !DQS_O)[*6])
        else $error("strobe not held low between bursts");
    chk_dll_release: assert property ((!(DLL_ENABLE_I && DLL_LOCKED_I))[*5] |-> !DQ_OE_O && !DQS_OE_O)
        else $error("outputs driven while delay loop not ready");
    chk_read_delay: assert property (READ_DELAY_O == $past(rl_exp))
        else $error("total read delay wrong");
    chk_fetch_spacing: assert property (RD_REQ_O |=> (!RD_REQ_O)[*8])
        else $error("fetch requests too close");
endmodule // ddrrd_chk
bind ddrrd_read_path ddrrd_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .COL_LATENCY_I(COL_LATENCY_I),
    .ADDITIVE_SEL_I(ADDITIVE_SEL_I), .DLL_ENABLE_I(DLL_ENABLE_I), .DLL_LOCKED_I(DLL_LOCKED_I),
    .RD_REQ_O(RD_REQ_O), .DQ_OE_O(DQ_OE_O), .DQS_O(DQS_O), .DQS_N_O(DQS_N_O), .DQS_OE_O(DQS_OE_O),
    .READ_DELAY_O(READ_DELAY_O));

// ---- ddrrd_ctrl_model.sv ----
// ddrrd_ctrl_model.sv: controller side: free running link clock and command and address pins.
// assumes commands launch on link clock falling edges so they are steady at the next rise.
`timescale 1ns/10ps
module ddrrd_ctrl_model (
    output reg ck_o,
    output reg [3:0] cmd_o,
    output reg [13:0] addr_o,
    output reg [2:0] bank_o,
    output reg [15:0] rise_cnt_o = 16'h0
);
    initial begin
        ck_o = 1'b0;
        cmd_o = 4'h7;
        addr_o = 14'h0;
        bank_o = 3'h0;
        #7;
        forever #40 ck_o = ~ck_o;
    end
    always @(posedge ck_o) rise_cnt_o <= rise_cnt_o + 16'h1;
    task issue(input [3:0] cmd, input [13:0] addr, input [2:0] bank);
        @(negedge ck_o);
        cmd_o = cmd;
        addr_o = addr;
        bank_o = bank;
        @(negedge ck_o);
        cmd_o = 4'h7;
        // released address must not keep showing the command's value
        addr_o = ~addr;
        bank_o = ~bank;
    endtask
    task wait_ck(input [4:0] n);
        repeat (n) @(negedge ck_o);
    endtask
endmodule // ddrrd_ctrl_model

// ---- ddrrd_read_path_tb.sv ----
// ddrrd_read_path_tb.sv: self-checking bench for the read path; the bench plays the array.
// assumes the controller model drives link clock and commands.
`timescale 1ns/10ps
module ddrrd_read_path_tb;
    reg sys_clk, rst, dll_en, dll_lk;
    reg [1:0] mode, als;
    reg [3:0] cl;
    reg [63:0] rd_data;
    wire ck, rd_req, dq_oe, dqs, dqs_n, dqs_oe;
    wire [3:0] cmd;
    wire [13:0] addr;
    wire [2:0] bank, rd_bank;
    wire [15:0] rises;
    wire [9:0] rd_col;
    wire [7:0] dq;
    wire [4:0] rl;
    integer err_total = 0;
    integer n_checks = 0;
    reg [7:0] beats[$];
    reg [15:0] base, t_dqs_on, t_dq_on, t_dq_off;
    reg [9:0] col_seen;
    reg oe_q = 1'b0, dqs_q = 1'b0, dqs_oe_q = 1'b0, arr_q = 1'b0;
    ddrrd_ctrl_model u_ctl (.ck_o(ck), .cmd_o(cmd), .addr_o(addr), .bank_o(bank), .rise_cnt_o(rises));
    ddrrd_read_path dut (.SYS_CLK_I(sys_clk), .RST_I(rst), .CK_I(ck), .CS_N_I(cmd[3]), .RAS_N_I(cmd[2]),
        .CAS_N_I(cmd[1]), .WE_N_I(cmd[0]), .ADDR_I(addr), .BANK_I(bank), .BURST_MODE_I(mode),
        .COL_LATENCY_I(cl), .ADDITIVE_SEL_I(als), .DLL_ENABLE_I(dll_en), .DLL_LOCKED_I(dll_lk),
        .RD_REQ_O(rd_req), .RD_COL_O(rd_col), .RD_BANK_O(rd_bank), .RD_DATA_I(rd_data), .DQ_O(dq),
        .DQ_OE_O(dq_oe), .DQS_O(dqs), .DQS_N_O(dqs_n), .DQS_OE_O(dqs_oe), .READ_DELAY_O(rl));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // array: the burst stands in the cycle after the fetch pulse, where the path takes it
    always @(negedge sys_clk) begin : array
        integer k;
        arr_q <= rd_req;
        for (k = 0; k < 8; k = k + 1) rd_data[k*8 +: 8] <= arr_q ? {1'b0, k[2:0], 1'b1, rd_bank} : ~rd_data[k*8 +: 8];
    end
    always @(posedge sys_clk) begin
        if (rd_req) col_seen <= rd_col;
        if (dqs_oe && !dqs_oe_q && t_dqs_on == 16'h0) t_dqs_on <= rises - base;
        if (dq_oe && !oe_q && t_dq_on == 16'h0) t_dq_on <= rises - base;
        if (!dq_oe && oe_q) t_dq_off <= rises - base;
        if (dq_oe && (!oe_q || dqs != dqs_q)) beats.push_back(dq);
        oe_q <= dq_oe;
        dqs_q <= dqs;
        dqs_oe_q <= dqs_oe;
    end
    task check(input [15:0] seen, input [15:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task clear;
        @(negedge sys_clk);
        beats.delete();
        t_dqs_on = 16'h0;
        t_dq_on = 16'h0;
        t_dq_off = 16'h0;
    endtask
    // one read, then command c2 gap link cycles later, then compare the whole answer
    task run(input [1:0] m, input [3:0] c, input [1:0] a, input [13:0] ad, input [2:0] bk,
        input [4:0] erl, input [3:0] nb, input [3:0] gap, input [3:0] c2);
        integer i;
        reg [15:0] e_off;
        clear();
        mode = m;
        cl = c;
        als = a;
        u_ctl.issue(4'h5, ad, bk);
        base = rises;
        u_ctl.wait_ck(gap - 4'h2);
        u_ctl.issue(c2, ad, bk);
        u_ctl.wait_ck(erl + 5'h6);
        e_off = erl + (nb >> 1) + ((c2 == 4'h5) ? gap : 4'h0);
        check(rl, erl);
        check(t_dqs_on, erl - 5'h1);
        check(t_dq_on, erl);
        check(t_dq_off, e_off);
        check(col_seen, ad[9:0]);
        check(beats.size(), (c2 == 4'h5) ? nb * 2 : nb);
        for (i = 0; i < beats.size(); i = i + 1) check(beats[i], {1'b0, ad[2] ^ i[2], ad[1:0] + i[1:0], 1'b1, bk});
        $display("test done: mode %0d delay %0d gap %0d", m, erl, gap);
    endtask
    initial begin
        rst = 1'b1;
        dll_en = 1'b1;
        dll_lk = 1'b1;
        mode = 2'h0;
        cl = 4'h5;
        als = 2'h0;
        rd_data = 64'h0;
        base = 16'h0;
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        run(2'h0, 4'h5, 2'h0, 14'h02a5, 3'h2, 5'h5, 4'h8, 4'h2, 4'h2);
        run(2'h1, 4'h6, 2'h1, 14'h0c34, 3'h5, 5'hb, 4'h4, 4'h4, 4'h7);
        run(2'h2, 4'h7, 2'h2, 14'h1030, 3'h1, 5'hc, 4'h4, 4'h4, 4'h7);
        run(2'h1, 4'h5, 2'h1, 14'h1ea5, 3'h3, 5'h9, 4'h8, 4'h5, 4'h5);
        run(2'h0, 4'hd, 2'h0, 14'h0007, 3'h6, 5'hd, 4'h8, 4'h4, 4'h5);
        run(2'h3, 4'h4, 2'h3, 14'h0008, 3'h4, 5'h5, 4'h8, 4'h4, 4'h7);
        clear();
        dll_lk = 1'b0;
        u_ctl.issue(4'h5, 14'h1000, 3'h0);
        base = rises;
        u_ctl.wait_ck(5'h14);
        check(beats.size(), 16'h0);
        check(t_dqs_on, 16'h0);
        $display("test done: delay loop unlocked");
        test_done();
    end
    initial begin
        #100000;
        err_total = err_total + 1;
        test_done();
    end
endmodule // ddrrd_read_path_tb
